// ---- logic/crt_sequencer.sv ----
// Readout timing sequencer: counters, slice state machine, strobes, links.
// Assumes clk_in is the master clock and ADC words arrive on pins.
`timescale 1ns/10ps
`default_nettype none

module crt_sequencer #(
	parameter logic [10:0] P_PAR_PIX    = crt_pkg::PAR_PIX,
	parameter logic [10:0] P_SER_PIX    = crt_pkg::SER_PIX,
	parameter logic [10:0] P_READ_LINES = crt_pkg::READ_LINES,
	parameter logic [20:0] P_SLICE_PIX  = crt_pkg::SLICE_PIX,
	parameter logic [11:0] P_MS_PIX     = crt_pkg::MS_PIX,
	parameter logic [10:0] P_GD_SER_PIX = crt_pkg::GD_SER_PIX
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Control
	input  wire logic             reverse_in,
	input  wire logic             inject_req_in,
	input  wire logic [12:0]      delay_ms_in,
	// Converter results
	input  wire logic [3:0][15:0] sci_adc_in,
	input  wire logic [15:0]      gd_adc_in,
	// Science drive
	output logic      [3:0]       sci_par_out,
	output logic      [3:0]       sci_ser_out,
	output logic                  inject_out,
	output logic      [2:0]       sci_cds_out,
	output logic      [2:0]       mux_sel_out,
	// Guidance drive
	output logic      [3:0]       gd_par_out,
	output logic      [3:0]       gd_ser_out,
	output logic      [2:0]       gd_cds_out,
	// Serial links
	output logic      [3:0]       sci_link_a_out,
	output logic      [3:0]       sci_link_b_out,
	output logic                  gd_link_a_out,
	output logic                  gd_link_b_out,
	// Status
	output logic                  expo_start_out,
	output logic      [1:0]       state_out
);
	import crt_pkg::*;

	// ------------------------------------------------------------
	// Derived lengths
	// ------------------------------------------------------------
	localparam logic [10:0] LINE_LAST  = 11'(P_PAR_PIX + P_SER_PIX - 11'd1);
	localparam logic [10:0] ROWS_LAST  = 11'(P_READ_LINES - 11'd1);
	localparam logic [20:0] SLICE_LAST = 21'(P_SLICE_PIX - 21'd1);
	localparam logic [11:0] MS_LAST    = 12'(P_MS_PIX - 12'd1);
	localparam logic [2:0]  SLICE_TOP  = 3'(SLICES - 3'd1);
	localparam logic [10:0] GD_LINE_LAST =
		11'(GD_PAR_PIX + P_GD_SER_PIX - 11'd1);
	localparam int GD_FRM_I = int'(P_READ_LINES)
		* (int'(P_PAR_PIX) + int'(P_SER_PIX)) / GUIDE_FRAMES;
	localparam logic [18:0] GD_FRM_LAST = 19'(GD_FRM_I - 1);
	localparam logic [15:0] SER_CYC = 16'(int'(P_SER_PIX) * PIX_CLKS);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	crt_state_t       state_q, state_d;
	logic [3:0]       pix_q;
	logic [10:0]      pos_q, line_q, gpos_q;
	logic [20:0]      sp_q;
	logic [2:0]       slc_q;
	logic [12:0]      ms_q, dly_q;
	logic [11:0]      msp_q;
	logic [18:0]      gfr_q;
	logic             rev_q, inj_en_q;
	logic [3:0][15:0] sadc1_q, sadc2_q, smp_q;
	logic [15:0]      gadc1_q, gadc2_q, gsmp_q;
	logic             svld_q, gvld_q;
	logic [2:0]       scds_q, gcds_q;
	logic             inj_q, expo_q;
	logic [15:0]      ser_cyc_q;

	// ------------------------------------------------------------
	// Decodes
	// ------------------------------------------------------------
	// Pixel tick and science line position
	wire tick      = pix_q == PIX_LAST;
	wire rd        = state_q == ST_READ;
	wire dl        = state_q == ST_DELAY;
	wire eol       = rd && tick && pos_q == LINE_LAST;
	wire read_end  = eol && line_q == ROWS_LAST;
	wire slice_end = !dl && tick && sp_q == SLICE_LAST;
	wire last_slc  = slc_q == SLICE_TOP;
	wire dly_end   = dl && tick && msp_q == MS_LAST
		&& ms_q == 13'(dly_q - 13'd1);
	wire cyc_start = (slice_end && last_slc && dly_q == 13'h0000)
		|| dly_end;
	wire rd_go     = !rd && state_d == ST_READ;

	// Science clock phases
	wire par_act   = rd && pos_q < P_PAR_PIX;
	wire ser_act   = rd && !par_act;
	wire [1:0] par_step = pos_q < PAR_STEP ? 2'h0
		: pos_q < 11'(PAR_STEP * 2) ? 2'h1
		: pos_q < 11'(PAR_STEP * 3) ? 2'h2 : 2'h3;

	// Guidance line and frame, locked to readout start
	wire gd_run    = !dl;
	wire gpar      = gd_run && gpos_q < GD_PAR_PIX;
	wire gser      = gd_run && !gpar;
	wire frm_wrap  = gd_run && tick && gfr_q == GD_FRM_LAST;
	wire gline_end = gd_run && tick && gpos_q == GD_LINE_LAST;

	// Sample strobes, same phases on both sensors
	wire [2:0] pix_cds = {pix_q == PH_CONVERT, pix_q == PH_CLAMP_OFF,
		pix_q == PH_CLAMP_ON};
	wire [2:0] scds_d = ser_act ? pix_cds : 3'h0;
	wire [2:0] gcds_d = gser ? pix_cds : 3'h0;

	// Word selection for the links
	wire        ld        = pix_q == PH_LOAD;
	wire        sync_now  = rd && pos_q == 11'd1;
	wire [15:0] sync_w    = line_q == 11'd0 ? SYNC_FRAME : SYNC_LINE;
	wire        gsync_now = gd_run && gpos_q == 11'd1;
	wire [15:0] gsync_w   = gfr_q <= 19'(GD_LINE_LAST) ? SYNC_FRAME
		: SYNC_LINE;
	wire [15:0] gword = gvld_q ? gsmp_q
		: gsync_now ? gsync_w : 16'h0000;

	// Injection window and delay limit
	wire inj_row = line_q >= INJ_ROW_FIRST && line_q <= INJ_ROW_LAST;
	wire inj_d   = rd && inj_en_q && inj_row;
	wire [12:0] dly_lim = delay_ms_in > MAX_DLY_MS ? MAX_DLY_MS
		: delay_ms_in;

	// ------------------------------------------------------------
	// Next values of the counters
	// ------------------------------------------------------------
	wire [10:0] pos_d  = !rd ? 11'h000 : eol ? 11'h000
		: tick ? 11'(pos_q + 11'd1) : pos_q;
	wire [10:0] line_d = !rd ? 11'h000
		: eol ? 11'(line_q + 11'd1) : line_q;
	wire [20:0] sp_d   = (slice_end || dl) ? 21'h000000
		: tick ? 21'(sp_q + 21'd1) : sp_q;
	wire [2:0]  slc_d  = !slice_end ? slc_q
		: last_slc ? 3'h0 : 3'(slc_q + 3'd1);
	wire [11:0] msp_d  = !dl ? 12'h000 : !tick ? msp_q
		: msp_q == MS_LAST ? 12'h000 : 12'(msp_q + 12'd1);
	wire [12:0] ms_d   = !dl ? 13'h0000
		: (tick && msp_q == MS_LAST) ? 13'(ms_q + 13'd1) : ms_q;
	wire [10:0] gpos_d = (rd_go || gline_end || frm_wrap) ? 11'h000
		: (gd_run && tick) ? 11'(gpos_q + 11'd1) : gpos_q;
	wire [18:0] gfr_d  = (rd_go || frm_wrap) ? 19'h00000
		: (gd_run && tick) ? 19'(gfr_q + 19'd1) : gfr_q;

	// Slice state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_READ:  if (read_end) state_d = ST_GAP;
			ST_GAP:   if (slice_end) state_d = (last_slc && dly_q != 13'h0000)
				? ST_DELAY : ST_READ;
			ST_DELAY: if (dly_end) state_d = ST_READ;
			default:  state_d = ST_READ;
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Timing counters
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_READ;
			pix_q   <= 4'h0;
			pos_q   <= 11'h000;
			line_q  <= 11'h000;
			sp_q    <= 21'h000000;
			slc_q   <= 3'h0;
		end else begin
			state_q <= state_d;
			pix_q   <= 4'(pix_q + 4'd1);
			pos_q   <= pos_d;
			line_q  <= line_d;
			sp_q    <= sp_d;
			slc_q   <= slc_d;
		end
	end

	// Delay and guidance counters
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			msp_q  <= 12'h000;
			ms_q   <= 13'h0000;
			gpos_q <= 11'h000;
			gfr_q  <= 19'h00000;
		end else begin
			msp_q  <= msp_d;
			ms_q   <= ms_d;
			gpos_q <= gpos_d;
			gfr_q  <= gfr_d;
		end
	end

	// Settings taken only at a cycle start
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rev_q    <= 1'b0;
			inj_en_q <= 1'b0;
			dly_q    <= 13'h0000;
		end else if (cyc_start) begin
			rev_q    <= reverse_in;
			inj_en_q <= inject_req_in && !reverse_in;
			dly_q    <= dly_lim;
		end
	end

	// Converter words, two stages from the pins
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sadc1_q <= '0;
			sadc2_q <= '0;
			gadc1_q <= 16'h0000;
			gadc2_q <= 16'h0000;
		end else begin
			sadc1_q <= sci_adc_in;
			sadc2_q <= sadc1_q;
			gadc1_q <= gd_adc_in;
			gadc2_q <= gadc1_q;
		end
	end

	// Sample capture, all four chains together
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			smp_q  <= '0;
			gsmp_q <= 16'h0000;
			svld_q <= 1'b0;
			gvld_q <= 1'b0;
		end else if (pix_q == PH_CAPTURE) begin
			smp_q  <= sadc2_q;
			gsmp_q <= gadc2_q;
			svld_q <= ser_act;
			gvld_q <= gser;
		end
	end

	// Strobe and status outputs
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scds_q    <= 3'h0;
			gcds_q    <= 3'h0;
			inj_q     <= 1'b0;
			expo_q    <= 1'b0;
			ser_cyc_q <= 16'h0000;
		end else begin
			scds_q    <= scds_d;
			gcds_q    <= gcds_d;
			inj_q     <= inj_d;
			expo_q    <= cyc_start;
			ser_cyc_q <= ser_act ? 16'(ser_cyc_q + 16'd1) : 16'h0000;
		end
	end

	assign sci_cds_out    = scds_q;
	assign gd_cds_out     = gcds_q;
	assign inject_out     = inj_q;
	assign mux_sel_out    = slc_q;
	assign expo_start_out = expo_q;
	assign state_out      = state_q;

	// ------------------------------------------------------------
	// Phase drivers
	// ------------------------------------------------------------
	// Science parallel phases, reversed in test state
	crt_phase u_sci_par (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.run_in   (par_act),
		.rev_in   (rev_q),
		.step_in  (par_step),
		.ph_out   (sci_par_out)
	);

	// Science serial phases, four steps per pixel
	crt_phase u_sci_ser (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.run_in   (ser_act),
		.rev_in   (1'b0),
		.step_in  (pix_q[3:2]),
		.ph_out   (sci_ser_out)
	);

	// Guidance parallel phases
	crt_phase u_gd_par (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.run_in   (gpar),
		.rev_in   (1'b0),
		.step_in  (gpos_q[3:2]),
		.ph_out   (gd_par_out)
	);

	// Guidance serial phases at the science pixel rate
	crt_phase u_gd_ser (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.run_in   (gser),
		.rev_in   (1'b0),
		.step_in  (pix_q[3:2]),
		.ph_out   (gd_ser_out)
	);

	// ------------------------------------------------------------
	// Serial links
	// ------------------------------------------------------------
	// One science link pair per chain
	for (genvar g = 0; g < 4; g++) begin : g_chain
		wire [15:0] sword = svld_q ? smp_q[g]
			: sync_now ? sync_w : 16'h0000;
		crt_link u_link (
			.clk_in    (clk_in),
			.rst_n_in  (rst_n_in),
			.load_in   (ld),
			.word_in   (sword),
			.bit_a_out (sci_link_a_out[g]),
			.bit_b_out (sci_link_b_out[g])
		);
	end

	// Guidance link pair
	crt_link u_gd_link (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.load_in   (ld),
		.word_in   (gword),
		.bit_a_out (gd_link_a_out),
		.bit_b_out (gd_link_b_out)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_clamp_on;
		sci_cds_out == 3'b001;
	endsequence
	sequence s_line_sync;
		rd && ld && pos_q == 11'd1 && line_q != 11'h000 && !svld_q;
	endsequence
	sequence s_frame_sync;
		rd && ld && pos_q == 11'd1 && line_q == 11'h000 && !svld_q;
	endsequence

	property p_pix_period;
		tick |-> ##16 tick;
	endproperty
	a_pix_period: assert property (p_pix_period)
		else $error("pixel period not sixteen clocks");
	property p_par_quiet;
		sci_cds_out != 3'h0 |-> $past(ser_act);
	endproperty
	a_par_quiet: assert property (p_par_quiet)
		else $error("strobe outside serial transfer");
	property p_ser_len;
		$fell(ser_act) |-> ser_cyc_q == SER_CYC;
	endproperty
	a_ser_len: assert property (p_ser_len)
		else $error("serial transfer length wrong");
	property p_guide_lock;
		read_end |-> frm_wrap;
	endproperty
	a_guide_lock: assert property (p_guide_lock)
		else $error("guidance frame not aligned to readout end");
	property p_mux_slice;
		$changed(mux_sel_out) |-> $past(state_q) != ST_READ;
	endproperty
	a_mux_slice: assert property (p_mux_slice)
		else $error("selector moved during readout");
	property p_pause;
		dl && $past(dl) |-> sci_cds_out == 3'h0 && gd_cds_out == 3'h0
			&& !inject_out;
	endproperty
	a_pause: assert property (p_pause)
		else $error("activity during delay");
	property p_cds_order;
		s_clamp_on |-> ##4 sci_cds_out == 3'b010 ##4 sci_cds_out == 3'b100;
	endproperty
	a_cds_order: assert property (p_cds_order)
		else $error("sampling strobes out of order");
	property p_inj_fwd;
		inject_out |-> !rev_q;
	endproperty
	a_inj_fwd: assert property (p_inj_fwd)
		else $error("injection while reversed");
	property p_inj_row;
		$rose(inject_out) |-> $past(line_q) == INJ_ROW_FIRST;
	endproperty
	a_inj_row: assert property (p_inj_row)
		else $error("injection on wrong row");
	property p_sync_word;
		s_line_sync |=> sci_link_a_out[0] == SYNC_LINE[15]
			##1 sci_link_a_out[0] == SYNC_LINE[14]
			##1 sci_link_a_out[0] == SYNC_LINE[13];
	endproperty
	a_sync_word: assert property (p_sync_word)
		else $error("line sync word not sent");
	property p_frame_sync;
		s_frame_sync |=> sci_link_a_out[3] == SYNC_FRAME[15]
			##1 sci_link_a_out[3] == SYNC_FRAME[14]
			##1 sci_link_a_out[3] == SYNC_FRAME[13];
	endproperty
	a_frame_sync: assert property (p_frame_sync)
		else $error("frame sync word not sent");
	property p_mode_hold;
		$changed(rev_q) |-> $past(cyc_start);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode changed outside cycle start");

endmodule : crt_sequencer

`default_nettype wire

// ---- include/crt_pkg.sv ----
// Shared constants and types of the readout timing sequencer.
// Assumes clk_in is the 48 MHz master clock; pixel phases are in its cycles, line, slice and guidance lengths in pixels, durations in ms.
package crt_pkg;

	// ------------------------------------------------------------
	// Pixel timing
	// ------------------------------------------------------------
	localparam int          MASTER_HZ   = 48_000_000;
	localparam int          PIX_CLKS    = 16;
	localparam int          PIX_RATE_HZ = MASTER_HZ / PIX_CLKS;
	localparam logic [3:0]  PIX_LAST    = 4'(PIX_CLKS - 1);
	localparam logic [3:0]  PH_LOAD      = 4'h0;
	localparam logic [3:0]  PH_CLAMP_ON  = 4'h2;
	localparam logic [3:0]  PH_CLAMP_OFF = 4'h6;
	localparam logic [3:0]  PH_CONVERT   = 4'ha;
	localparam logic [3:0]  PH_CAPTURE   = 4'hf;

	// ------------------------------------------------------------
	// Science line and frame
	// ------------------------------------------------------------
	localparam logic [10:0] PAR_PIX      = 11'd323;
	localparam logic [10:0] SER_PIX      = 11'd1132;
	localparam logic [10:0] PAR_STEP     = 11'd80;
	localparam int          READ_MS      = 520;
	localparam int          LINE_PIX_I   = 323 + 1132;
	localparam logic [10:0] READ_LINES   =
		11'(READ_MS * (PIX_RATE_HZ / 1000) / LINE_PIX_I);
	localparam logic [10:0] INJ_ROW_FIRST = 11'd1059;
	localparam logic [10:0] INJ_ROW_LAST  = 11'd1062;

	// ------------------------------------------------------------
	// Slices and integration
	// ------------------------------------------------------------
	localparam int          SLICE_MS     = 600;
	localparam logic [2:0]  SLICES       = 3'd5;
	localparam logic [20:0] SLICE_PIX    =
		21'(SLICE_MS * (PIX_RATE_HZ / 1000));
	localparam logic [11:0] MS_PIX       = 12'(PIX_RATE_HZ / 1000);
	localparam int          MAX_INT_MS   = 8000;
	localparam logic [12:0] MAX_DLY_MS   = 13'(MAX_INT_MS - SLICE_MS * 5);

	// ------------------------------------------------------------
	// Guidance sensor
	// ------------------------------------------------------------
	localparam int          GUIDE_FRAMES = 5;
	localparam logic [10:0] GD_PAR_PIX   = 11'd16;
	localparam logic [10:0] GD_SER_PIX   = 11'd1000;

	// ------------------------------------------------------------
	// Link words
	// ------------------------------------------------------------
	localparam int           WORD_W     = 16;
	localparam logic [15:0]  SYNC_FRAME = 16'hfb47;
	localparam logic [15:0]  SYNC_LINE  = 16'hd2c1;

	typedef enum logic [1:0] {
		ST_READ  = 2'b00,
		ST_GAP   = 2'b01,
		ST_DELAY = 2'b10
	} crt_state_t;

endpackage : crt_pkg

// ---- logic/crt_phase.sv ----
// Four-phase clock pattern generator with forward or reversed order.
// Assumes step_in advances in order; holds its pattern while idle.
`timescale 1ns/10ps
`default_nettype none

module crt_phase (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Step control
	input  wire logic       run_in,
	input  wire logic       rev_in,
	input  wire logic [1:0] step_in,
	// Phase drive
	output logic      [3:0] ph_out
);
	// Reversed order walks the pattern backwards
	wire [1:0] idx = rev_in ? ~step_in : step_in;
	logic [3:0] pat;

	// Two adjacent phases high per step
	always_comb begin
		case (idx)
			2'h0:    pat = 4'h3;
			2'h1:    pat = 4'h6;
			2'h2:    pat = 4'hc;
			default: pat = 4'h9;
		endcase
	end

	// Pattern register, frozen while paused
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ph_out <= 4'h3;
		end else if (run_in) begin
			ph_out <= pat;
		end
	end

endmodule : crt_phase

`default_nettype wire

// ---- logic/crt_link.sv ----
// Word serializer feeding one redundant pair of serial links.
// Assumes load_in pulses once every word length of clocks.
`timescale 1ns/10ps
`default_nettype none

module crt_link (
	// Clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       rst_n_in,
	// Word to send
	input  wire logic                       load_in,
	input  wire logic [crt_pkg::WORD_W-1:0] word_in,
	// Redundant link pair
	output logic                            bit_a_out,
	output logic                            bit_b_out
);
	import crt_pkg::*;

	logic [WORD_W-1:0] sh_q;
	wire  [WORD_W-1:0] sh_d = load_in ? word_in
		: {sh_q[WORD_W-2:0], 1'b0};

	// Shift register, most significant bit first
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sh_q <= '0;
		end else begin
			sh_q <= sh_d;
		end
	end

	// Both links carry the same bit
	assign bit_a_out = sh_q[WORD_W-1];
	assign bit_b_out = sh_q[WORD_W-1];

endmodule : crt_link

`default_nettype wire

// ---- verification/crt_acc_model.sv ----
// Pixel accumulator model on one serial link bit stream.
// Assumes MSB-first bits, one per clock, words framed by sync words.
`timescale 1ns/10ps
`default_nettype none

module crt_acc_model (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Link bit
	input  wire logic        bit_in,
	// Running totals
	output logic      [31:0] sum_out,
	output logic      [31:0] words_out,
	output logic      [31:0] frames_out
);
	import crt_pkg::*;

	logic [15:0] sh;
	logic        lock;
	int          cnt;

	// ------------------------------------------------------------
	// Sync search, word framing, summing
	// ------------------------------------------------------------
	// Before lock every bit position is searched for a sync word
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sh = '0;
			lock = 1'b0;
			cnt = 0;
			sum_out <= '0;
			words_out <= '0;
			frames_out <= '0;
		end else begin
			sh = {sh[14:0], bit_in};
			cnt = cnt + 1;
			if (!lock || cnt == 16) begin
				cnt = 0;
				if (sh == SYNC_FRAME || sh == SYNC_LINE) begin
					lock = 1'b1;
					if (sh == SYNC_FRAME) begin
						frames_out <= frames_out + 32'h1;
					end
				end else if (lock && sh != 16'h0000) begin
					sum_out <= sum_out + 32'(sh);
					words_out <= words_out + 32'h1;
				end
			end
		end
	end

endmodule : crt_acc_model
`default_nettype wire

// ---- verification/crt_sequencer_tb.sv ----
// Self-checking bench of the readout timing sequencer.
// Assumes shortened line and slice counts; accumulators on all chains.
`timescale 1ns/10ps
`default_nettype none

module crt_sequencer_tb;
	import crt_pkg::*;

	localparam int SLICE_CLK = 330 * 16;
	localparam int CYC_CLK   = 5 * SLICE_CLK;
	localparam int DLY_CLK   = 2 * 4 * 16;
	localparam int T_LIMIT   = 90000;

	logic             clk_in = 1'b0;
	logic             rst_n_in = 1'b0;
	logic             reverse_in = 1'b1;
	logic             inject_req_in = 1'b1;
	logic [12:0]      delay_ms_in = 13'h0002;
	logic [3:0][15:0] sci_adc_in;
	logic [15:0]      gd_adc_in = 16'h0000;
	logic [3:0]       sci_par_out, sci_ser_out, gd_par_out, gd_ser_out;
	logic [3:0]       sci_link_a_out, sci_link_b_out, last_par, last_ser;
	logic [3:0]       last_gp, last_gs;
	logic [2:0]       sci_cds_out, gd_cds_out, mux_sel_out, last_mux = 3'h0;
	logic [1:0]       state_out;
	logic             inject_out, gd_link_a_out, gd_link_b_out;
	logic             expo_start_out, ref_dir, dir, mux_seen = 1'b0;
	logic [31:0]      acc_sum [4], acc_words [4], acc_frames [4];
	logic [31:0]      b_sum [4], b_words [4], b_frames [4];
	logic [31:0]      rng = 32'h5412;
	logic [15:0]      v;
	int err_count = 0, total_checks = 0, tick = 0, last_expo = 0, k = 0;
	int sc = 0, conv = 0, dly = 0, moves = 0, fwd = 0, rev = 0, inj = 0;
	int since = 0, dly_since = 0, ab_bad = 0, exp_sum;
	int exp_q [$];

	always #50 clk_in = ~clk_in;

	// ------------------------------------------------------------
	// Design and far-side models
	// ------------------------------------------------------------
	crt_sequencer #(.P_SER_PIX(11'd2),
		.P_READ_LINES(11'd1), .P_SLICE_PIX(21'd330), .P_MS_PIX(12'd4),
		.P_GD_SER_PIX(11'd8)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.reverse_in(reverse_in), .inject_req_in(inject_req_in),
		.delay_ms_in(delay_ms_in), .sci_adc_in(sci_adc_in),
		.gd_adc_in(gd_adc_in), .sci_par_out(sci_par_out),
		.sci_ser_out(sci_ser_out), .inject_out(inject_out),
		.sci_cds_out(sci_cds_out), .mux_sel_out(mux_sel_out),
		.gd_par_out(gd_par_out), .gd_ser_out(gd_ser_out),
		.gd_cds_out(gd_cds_out), .sci_link_a_out(sci_link_a_out),
		.sci_link_b_out(sci_link_b_out), .gd_link_a_out(gd_link_a_out),
		.gd_link_b_out(gd_link_b_out), .expo_start_out(expo_start_out),
		.state_out(state_out));

	for (genvar c = 0; c < 4; c++) begin : g_acc
		crt_acc_model u_acc (.clk_in(clk_in), .rst_n_in(rst_n_in),
			.bit_in(sci_link_a_out[c]), .sum_out(acc_sum[c]),
			.words_out(acc_words[c]), .frames_out(acc_frames[c]));
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// New constant sample per cycle; model sum is ten samples a cycle
	task automatic new_sample();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		v = (rng[15:0] & 16'h3fff) | 16'h0001;
		for (int c = 0; c < 4; c++) begin
			sci_adc_in[c] = v + 16'(c);
		end
		exp_q.push_back(10 * int'(v));
	endtask : new_sample

	initial begin
		new_sample();
		repeat (6) @(negedge clk_in);
		rst_n_in <= 1'b1;
	end

	// ------------------------------------------------------------
	// Monitor, per-cycle model compare and stimulus
	// ------------------------------------------------------------
	always @(negedge clk_in) begin
		if (rst_n_in) begin
			tick++;
			sc++;
			since++;
			gd_adc_in = rng[31:16] ^ 16'(tick);
			if (tick > T_LIMIT) begin
				err_count++;
				wrap_up();
			end
			if (sci_link_a_out !== sci_link_b_out) ab_bad++;
			if (gd_link_a_out !== gd_link_b_out) ab_bad++;
			if (inject_out !== 1'b0) inj++;
			if (sci_cds_out[0] === 1'b1) begin
				if (sc < 32) check(sc, 16);
				sc = 0;
			end
			if (sci_cds_out[1] === 1'b1) check(sc, 4);
			if (sci_cds_out[2] === 1'b1) begin
				check(sc, 8);
				conv++;
			end
			if (state_out === ST_DELAY) begin
				dly++;
				if (sci_cds_out !== 3'h0 || gd_cds_out !== 3'h0) moves++;
				if (sci_par_out !== last_par || sci_ser_out !== last_ser) moves++;
				if (dly > 1 && (gd_par_out !== last_gp
					|| gd_ser_out !== last_gs)) moves++;
			end
			if (sci_par_out === {last_par[2:0], last_par[3]}) fwd++;
			if (sci_par_out === {last_par[0], last_par[3:1]}) rev++;
			last_par = sci_par_out;
			last_ser = sci_ser_out;
			last_gp = gd_par_out;
			last_gs = gd_ser_out;
			if (mux_sel_out !== last_mux) begin
				if (mux_seen) begin
					check(since, SLICE_CLK + dly_since);
					check(mux_sel_out, (last_mux == 3'h4) ? 0 : last_mux + 1);
				end
				mux_seen = 1'b1;
				since = 0;
				dly_since = 0;
			end
			last_mux = mux_sel_out;
			if (state_out === ST_DELAY) dly_since++;
			if (expo_start_out === 1'b1) begin
				dir = fwd > rev;
				check(conv, 10);
				check(ab_bad, 0);
				check(inj, 0);
				check(moves, 0);
				check(fwd + rev > 0, 1);
				if (k == 0) ref_dir = dir;
				else check(dir, (k == 1) ? !ref_dir : ref_dir);
				check(dly, (k == 1) ? DLY_CLK : 0);
				if (k > 0) check(tick - last_expo, CYC_CLK + dly);
				exp_sum = exp_q.pop_front();
				for (int c = 0; c < 4; c++) begin
					check(acc_words[c] - b_words[c], 10);
					check(acc_sum[c] - b_sum[c], exp_sum + 10 * c);
					check(acc_frames[c] - b_frames[c], 5);
				end
				b_sum = acc_sum;
				b_words = acc_words;
				b_frames = acc_frames;
				{conv, dly, moves, fwd, rev, inj, ab_bad} = '0;
				last_expo = tick;
				reverse_in = 1'b0;
				delay_ms_in = 13'h0000;
				new_sample();
				k++;
				if (k == 3) wrap_up();
			end
		end else begin
			b_sum = '{default: 32'h0};
			b_words = '{default: 32'h0};
			b_frames = '{default: 32'h0};
		end
	end

endmodule : crt_sequencer_tb
`default_nettype wire
